// ==== sim/jbf_bus_node.sv ====
// far-side node model raising symbol events
`timescale 1ns/1ps
`default_nettype none
module jbf_bus_node
    import jbf_pkg::*;
(
    input wire logic clk_sys,
    output var jbf_link_ev_t link_ev
);
    // ----
    // events
    // ----
    initial link_ev = '0;
    // one-cycle pulse; released data shows its inverse
    task automatic send(input jbf_link_ev_t e);
        @(negedge clk_sys);
        link_ev = e;
        @(negedge clk_sys);
        link_ev = {6'h00, ~e.rx_data, 5'h00};
    endtask : send
endmodule : jbf_bus_node
`default_nettype wire

// ==== sim/jbf_monitor.sv ====
// port assertions for the frame-control block
`timescale 1ns/1ps
`default_nettype none
module jbf_monitor
    import jbf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] host_command_byte,
    input wire logic irq_enable,
    input wire jbf_link_ev_t link_ev,
    input wire logic tx_halt,
    input wire logic break_drive,
    input wire logic [1:0] tx_status,
    input wire logic rx_frame_done,
    input wire logic standby_req,
    input wire logic irq_n
);
    // ----
    // relations
    // ----
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire logic [2:0] ga = host_command_byte[GEN_HI:GEN_LO];
    wire logic [2:0] bt = host_command_byte[BTD_HI:BTD_LO];
    chk_break_cmd: assert property (cmd_valid && ga == GA_BREAK |-> break_drive)
        else $error("break not driven");
    chk_break_only: assert property (break_drive |-> cmd_valid && ga == GA_BREAK)
        else $error("stray break");
    chk_standby_cmd: assert property (cmd_valid && ga == GA_STANDBY |-> standby_req)
        else $error("no standby request");
    chk_break_halt: assert property (link_ev.brk |-> tx_halt)
        else $error("no halt on break");
    chk_break_irq: assert property (link_ev.brk && irq_enable |-> ##[1:3] !irq_n)
        else $error("no irq on break");
    chk_eod_done: assert property (link_ev.eod |-> ##[1:3] rx_frame_done)
        else $error("frame not flagged");
    chk_break_done: assert property (link_ev.brk |-> ##[1:3] rx_frame_done)
        else $error("break code missing");
    chk_first_some: assert property (cmd_valid && bt == BT_FIRST && ga == GA_NONE
        && tx_status == TXS_EMPTY |=> tx_status == TXS_SOME)
        else $error("first byte not held");
endmodule : jbf_monitor
`default_nettype wire

// ==== sim/test_jbf_frame_ctrl.sv ====
// self-checking bench for the frame-control block
`timescale 1ns/1ps
`default_nettype none
module test_jbf_frame_ctrl
    import jbf_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [7:0] host_command_byte = 8'h00;
    logic [7:0] cmd_data = 8'h00;
    logic rx_pop = 1'b0;
    logic irq_enable = 1'b1;
    jbf_link_ev_t link_ev;
    jbf_rx_entry_t rx_head;
    logic rx_empty;
    logic [1:0] tx_status;
    logic irq_n;
    logic tx_start;
    logic tx_byte_valid;
    logic [7:0] tx_byte;
    logic tx_send_crc;
    logic tx_crc_invert;
    logic tx_norm_bit_valid;
    logic normalization_bit;
    int n_errors = 0;
    int num_checks = 0;
    wire logic [8:0] st = {7'h00, tx_status};
    wire logic [8:0] iq = {8'h00, irq_n};
    always #2.5 clk_sys = ~clk_sys;
    jbf_bus_node node_u (.clk_sys, .link_ev);
    jbf_frame_ctrl dut_u (.clk_sys, .arst_n, .cmd_valid, .host_command_byte, .cmd_data,
        .rx_pop, .rx_head, .rx_empty, .irq_enable, .link_ev, .tx_start, .tx_byte_valid,
        .tx_byte, .tx_send_crc, .tx_crc_invert, .tx_norm_bit_valid,
        .normalization_bit, .tx_halt(), .break_drive(), .tx_status, .rx_frame_done(),
        .standby_req(), .irq_n);
    // ----
    // tasks
    // ----
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    function automatic jbf_link_ev_t ev(input logic [18:0] m, input logic [7:0] d);
        ev = m;
        ev.rx_data = d;
    endfunction : ev
    task automatic cmd(input logic [2:0] g, input logic [2:0] b, input logic [7:0] d);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        host_command_byte = {g, b, 2'b00};
        cmd_data = d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask : cmd
    // bounded wait, head settles a cycle after the push
    task automatic pop(output logic [8:0] h);
        int i;
        for (i = 0; i < 20 && rx_empty !== 1'b0; i++)
            @(negedge clk_sys);
        if (i == 20)
        begin
            n_errors++;
            report_and_stop();
        end
        @(negedge clk_sys);
        h = rx_head;
        rx_pop = 1'b1;
        @(negedge clk_sys);
        rx_pop = 1'b0;
        @(negedge clk_sys);
    endtask : pop
    // ----
    // sequence
    // ----
    initial
    begin
        int k;
        logic [8:0] h;
        repeat (20) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        cmd(GA_BREAK, BT_NONE, 8'h00);
        node_u.send(ev(19'h04000, 8'h00));
        repeat (2) @(negedge clk_sys);
        cmp(iq, 9'h000);
        pop(h);
        cmp(h & 9'h120, 9'h120);
        $display("break test done");
        node_u.send(ev(19'h40000, 8'h00));
        for (k = 0; k < 13; k++)
        begin
            cmp(iq, 9'h001);
            node_u.send(ev(19'h02000, 8'h30 + k[7:0]));
        end
        repeat (2) @(negedge clk_sys);
        cmp(iq, 9'h000);
        node_u.send(ev(19'h20010, 8'h00));
        for (k = 0; k < 13; k++)
        begin
            pop(h);
            cmp(h, {1'b0, 8'h30 + k[7:0]});
        end
        pop(h);
        cmp(h & 9'h101, 9'h100);
        $display("receive test done");
        for (k = 0; k < 4; k++)
            cmd(GA_NONE, k == 0 ? BT_FIRST : BT_DATA, 8'hA0 + k[7:0]);
        cmp(st, 9'h003);
        cmd(GA_NONE, BT_FIRST, 8'hEE);
        cmp(st, 9'h003);
        node_u.send(ev(19'h08000, 8'h00));
        cmp({8'h00, tx_start}, 9'h001);
        node_u.send(ev(19'h00001, 8'h00));
        cmp(st, 9'h002);
        node_u.send(ev(19'h00001, 8'h00));
        cmp(st, 9'h001);
        @(negedge clk_sys); // irq is a registered copy of the level
        cmp(iq, 9'h000);
        cmp({tx_byte_valid, tx_byte}, 9'h1A2);
        cmd(GA_NONE, BT_LAST, 8'hA4);
        cmp(st, 9'h003);
        for (k = 0; k < 3; k++)
            node_u.send(ev(19'h00001, 8'h00));
        cmp({7'h00, tx_send_crc, tx_crc_invert}, 9'h002);
        node_u.send(ev(19'h10000, 8'h00));
        repeat (2) @(negedge clk_sys);
        cmp(st, 9'h000);
        $display("block test done");
        // pending frame byte, then a response queued inside the next frame
        cmd(GA_NONE, BT_FIRST, 8'h77);
        node_u.send(ev(19'h40000, 8'h00));
        cmd(GA_RSP_CRC, BT_FIRST_LAST, 8'h55);
        node_u.send(ev(19'h20010, 8'h00));
        cmp({6'h00, tx_start, tx_norm_bit_valid, normalization_bit}, 9'h007);
        node_u.send(ev(19'h00001, 8'h00));
        cmp({tx_byte_valid, tx_byte}, 9'h155);
        cmp({8'h00, tx_send_crc}, 9'h001);
        node_u.send(ev(19'h02000, 8'h55));
        node_u.send(ev(19'h20010, 8'h00));
        node_u.send(ev(19'h10000, 8'h00));
        pop(h);
        cmp(h, 9'h100);
        pop(h);
        cmp(h, 9'h055);
        pop(h);
        cmp(h, 9'h1C0);
        cmd(GA_ABORT, BT_FIRST, 8'h77);
        cmp(st, 9'h001);
        cmd(GA_STANDBY, BT_NONE, 8'h00);
        $display("response test done");
        report_and_stop();
    end
endmodule : test_jbf_frame_ctrl
bind jbf_frame_ctrl jbf_monitor mon_u (.clk_sys, .arst_n, .cmd_valid, .host_command_byte,
    .irq_enable, .link_ev, .tx_halt, .break_drive, .tx_status, .rx_frame_done,
    .standby_req, .irq_n);
`default_nettype wire

// ==== src/jbf_frame_ctrl.sv ====
// frame control: block mode, break and in-frame response handling
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module jbf_frame_ctrl
    import jbf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cmd_valid,
    input wire logic [7:0] host_command_byte,
    input wire logic [7:0] cmd_data,
    input wire logic rx_pop,
    output jbf_rx_entry_t rx_head,
    output logic rx_empty,
    input wire logic irq_enable,
    input wire jbf_link_ev_t link_ev,
    output logic tx_start,
    output logic tx_byte_valid,
    output logic [7:0] tx_byte,
    output logic tx_send_crc,
    output logic tx_crc_invert,
    output logic tx_norm_bit_valid,
    output logic normalization_bit,
    output logic tx_halt,
    output logic break_drive,
    output logic [1:0] tx_status,
    output logic rx_frame_done,
    output logic standby_req,
    output logic irq_n
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;

    // async assert, sync release through two flops
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    logic [2:0] gen;
    logic [2:0] btd;
    logic is_first;
    logic is_last_cmd;
    logic is_data;
    logic rsp_cmd;

    assign gen = cmd_valid ? host_command_byte[GEN_HI:GEN_LO] : GA_NONE;
    assign btd = cmd_valid ? host_command_byte[BTD_HI:BTD_LO] : BT_NONE;
    assign is_first = (btd == BT_FIRST) || (btd == BT_FIRST_LAST);
    assign is_last_cmd = (btd == BT_LAST) || (btd == BT_FIRST_LAST);
    assign is_data = (btd == BT_DATA) || (btd == BT_LAST) || is_first;
    assign rsp_cmd = (gen == GA_RSP_CRC) || (gen == GA_RSP_NOCRC);

    // ------------------------------------------------------------------
    // transmit fifo
    // ------------------------------------------------------------------
    jbf_tx_entry_t txm [TX_DEPTH];
    logic [TX_AW-1:0] twr_q;
    logic [TX_AW-1:0] trd_q;
    logic [TX_AW:0] tcnt_q;
    logic tx_full;
    logic tx_empty;
    logic have_last_q;
    logic block_q;
    logic end_retry_q;
    logic retry_pend_q;
    logic rsp_q;
    logic rsp_crc_q;
    logic rsp_armed_q;
    logic in_frame_q;
    logic frame_err_q;
    logic underrun_q;
    logic sent_first_q;
    logic sent_second_q;
    jbf_tx_state_t st_q;
    logic push_tx;
    logic pop_tx;
    logic flush_tx;

    assign tx_full = (tcnt_q == (TX_AW+1)'(TX_DEPTH));
    assign tx_empty = (tcnt_q == '0);

    // first byte only into an idle fifo; dropped when full in block mode
    always_comb
    begin
        push_tx = 1'b0;
        // a response outside the frame window or without a head byte loads nothing
        if (is_data && (!tx_full || rsp_cmd))
        begin
            if (is_first)
                push_tx = rsp_cmd ? in_frame_q : (tx_empty || (gen == GA_ABORT));
            else
                push_tx = !rsp_cmd && !tx_empty && !have_last_q;
        end
        if (is_first && tx_full && block_q && !rsp_cmd)
            push_tx = 1'b0;
    end

    assign pop_tx = link_ev.tx_done_byte && (st_q == JBF_TX_SEND) && !tx_empty;

    // response errors and abort empty the fifo
    logic rsp_fail;
    assign rsp_fail = rsp_q && (link_ev.arb_lost || link_ev.tx_err);
    assign flush_tx = rsp_cmd || (gen == GA_ABORT) || rsp_fail
        || (st_q == JBF_TX_RSP_WAIT && link_ev.eod && (frame_err_q || link_ev.rx_err))
        || (end_retry_q && st_q == JBF_TX_CRC && link_ev.eof);

    // storage
    always_ff @(posedge clk_sys)
    begin
        if (push_tx)
            txm[flush_tx ? TX_AW'(0) : twr_q] <= '{last: is_last_cmd, value: cmd_data};
    end

    // pointers; flush then optional reload of the accompanying first byte
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            twr_q <= '0;
            trd_q <= '0;
            tcnt_q <= '0;
        end
        else if (flush_tx)
        begin
            trd_q <= '0;
            twr_q <= push_tx ? TX_AW'(1) : '0;
            tcnt_q <= push_tx ? (TX_AW+1)'(1) : '0;
        end
        else
        begin
            if (push_tx)
                twr_q <= twr_q + TX_AW'(1);
            if (pop_tx)
                trd_q <= trd_q + TX_AW'(1);
            tcnt_q <= tcnt_q + (TX_AW+1)'(push_tx) - (TX_AW+1)'(pop_tx);
        end
    end

    // last marker stays latched until the frame is fully out
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            have_last_q <= 1'b0;
        else if (flush_tx && !(push_tx && is_last_cmd))
            have_last_q <= 1'b0;
        else if (push_tx && is_last_cmd)
            have_last_q <= 1'b1;
        else if (st_q == JBF_TX_CRC && link_ev.eof)
            have_last_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // transmit control
    // ------------------------------------------------------------------
    logic start_normal;
    assign start_normal = !tx_empty && (have_last_q || tx_full) && !rsp_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= JBF_TX_IDLE;
        else if (gen == GA_ABORT || rsp_fail || link_ev.brk || flush_tx)
            st_q <= (rsp_cmd && is_first && in_frame_q) ? JBF_TX_RSP_WAIT : JBF_TX_IDLE;
        else
        begin
            case (st_q)
                JBF_TX_IDLE:
                    if (start_normal && (!retry_pend_q || link_ev.idle))
                        st_q <= JBF_TX_WAIT_BUS;
                JBF_TX_WAIT_BUS:
                    if (link_ev.idle)
                        st_q <= JBF_TX_SEND;
                JBF_TX_SEND:
                    if (pop_tx && txm[trd_q].last)
                        st_q <= JBF_TX_CRC;
                    else if (link_ev.arb_lost)
                        st_q <= JBF_TX_IDLE;
                JBF_TX_CRC:
                    if (link_ev.eof)
                        st_q <= JBF_TX_IDLE;
                JBF_TX_RSP_WAIT:
                    if (link_ev.eod)
                        st_q <= JBF_TX_SEND;
                default:
                    st_q <= JBF_TX_IDLE;
            endcase
        end
    end

    // block mode entered on a full fifo without last marker
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            block_q <= 1'b0;
        else if (st_q == JBF_TX_IDLE && tx_full && !have_last_q)
            block_q <= 1'b1;
        else if (st_q == JBF_TX_RSP_WAIT && link_ev.eod && !have_last_q)
            block_q <= 1'b1;
        else if (st_q == JBF_TX_IDLE && tx_empty)
            block_q <= 1'b0;
    end

    // end-retry request; block mode entry and an idle empty fifo cancel it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            end_retry_q <= 1'b0;
        else if (gen == GA_END_RETRY)
            end_retry_q <= 1'b1;
        else if (st_q == JBF_TX_IDLE && tx_full && !have_last_q)
            end_retry_q <= 1'b0;
        else if (st_q == JBF_TX_IDLE && tx_empty)
            end_retry_q <= 1'b0;
    end

    // retry after break when idle returns, never for responses
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            retry_pend_q <= 1'b0;
        else if (link_ev.brk && st_q != JBF_TX_IDLE && !rsp_q && !end_retry_q)
            retry_pend_q <= 1'b1;
        else if (link_ev.idle || rsp_q)
            retry_pend_q <= 1'b0;
    end

    // response bookkeeping: load window is sof to eod of the answered frame
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_q <= 1'b0;
            rsp_crc_q <= 1'b0;
            rsp_armed_q <= 1'b0;
        end
        else if (rsp_cmd && is_first && in_frame_q && push_tx)
        begin
            rsp_q <= 1'b1;
            rsp_crc_q <= (gen == GA_RSP_CRC);
            rsp_armed_q <= 1'b1;
        end
        else if (flush_tx || link_ev.brk || (st_q == JBF_TX_CRC && link_ev.eof))
        begin
            rsp_q <= 1'b0;
            rsp_armed_q <= 1'b0;
        end
        else if (link_ev.eod)
            rsp_armed_q <= 1'b0;
    end

    // frame window and receive error tracking
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_frame_q <= 1'b0;
            frame_err_q <= 1'b0;
        end
        else if (link_ev.sof)
        begin
            in_frame_q <= 1'b1;
            frame_err_q <= 1'b0;
        end
        else
        begin
            if (link_ev.eod || link_ev.idle)
                in_frame_q <= 1'b0;
            // an error on the eod cycle must still count
            if (link_ev.rx_err)
                frame_err_q <= 1'b1;
        end
    end

    // underrun: fifo ran dry mid-frame before any last byte
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            underrun_q <= 1'b0;
        else if (st_q == JBF_TX_SEND && tx_empty && !have_last_q)
            underrun_q <= 1'b1;
        else if (st_q == JBF_TX_IDLE)
            underrun_q <= 1'b0;
    end

    // byte stream and link controls
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_byte <= '0;
            tx_byte_valid <= 1'b0;
            tx_start <= 1'b0;
            normalization_bit <= 1'b0;
            tx_norm_bit_valid <= 1'b0;
        end
        else
        begin
            tx_byte <= txm[trd_q].value;
            tx_byte_valid <= (st_q == JBF_TX_SEND) && !tx_empty;
            tx_start <= (st_q == JBF_TX_WAIT_BUS && link_ev.idle)
                || (st_q == JBF_TX_RSP_WAIT && link_ev.eod);
            tx_norm_bit_valid <= (st_q == JBF_TX_RSP_WAIT && link_ev.eod);
            normalization_bit <= rsp_crc_q;
        end
    end

    // crc only when the frame carries one; underrun inverts it
    assign tx_send_crc = (st_q == JBF_TX_CRC) && (!rsp_q || rsp_crc_q) || underrun_q;
    assign tx_crc_invert = underrun_q;
    assign tx_halt = link_ev.brk || rsp_fail;
    assign break_drive = (gen == GA_BREAK);
    assign standby_req = (gen == GA_STANDBY);

    // block progress for status
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sent_first_q <= 1'b0;
            sent_second_q <= 1'b0;
        end
        else if (st_q == JBF_TX_IDLE)
        begin
            sent_first_q <= 1'b0;
            sent_second_q <= 1'b0;
        end
        else if (pop_tx)
        begin
            sent_first_q <= 1'b1;
            sent_second_q <= sent_first_q;
        end
    end

    // status field
    always_comb
    begin
        if (have_last_q)
            tx_status = TXS_FULL;
        else if (tx_empty)
            tx_status = TXS_EMPTY;
        else if (block_q && sent_second_q)
            tx_status = tx_full ? TXS_FULL : TXS_SOME;
        else if (block_q && sent_first_q)
            tx_status = TXS_ALMOST;
        else
            tx_status = tx_full ? TXS_FULL : TXS_SOME;
    end

    // ------------------------------------------------------------------
    // receive path
    // ------------------------------------------------------------------
    jbf_rx_entry_t rx_push_data;
    logic rx_push;
    logic rx_full;
    logic [RX_AW:0] rx_level;
    logic discard_q;
    logic rx_rsp_q;
    logic [7:0] cc;

    // completion code assembly
    always_comb
    begin
        cc = '0;
        cc[CC_RSP] = rx_rsp_q;
        cc[CC_RSP_CRC] = rx_rsp_q && rsp_crc_q;
        cc[CC_BREAK] = link_ev.brk;
        cc[CC_OVERRUN] = discard_q;
        cc[CC_UNDERRUN] = underrun_q;
        cc[CC_ARB_LOST] = link_ev.arb_lost;
        cc[CC_CRC_ERR] = link_ev.eod && !link_ev.crc_ok;
        cc[CC_ERR] = frame_err_q || discard_q || rsp_fail;
    end

    // code pushes win over data; a byte after overflow is discarded
    always_comb
    begin
        rx_push = 1'b0;
        rx_push_data = '{is_cc: 1'b0, value: link_ev.rx_data};
        if (link_ev.eod || link_ev.brk)
        begin
            rx_push = 1'b1;
            rx_push_data = '{is_cc: 1'b1, value: cc};
        end
        else if (link_ev.rx_byte && !discard_q && !rx_full)
            rx_push = 1'b1;
    end

    // overrun sticky for the rest of the frame
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            discard_q <= 1'b0;
        else if (link_ev.eod || link_ev.brk)
            discard_q <= 1'b0;
        else if (link_ev.rx_byte && rx_full)
            discard_q <= 1'b1;
    end

    // second frame after eod with a response queued is the response
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rx_rsp_q <= 1'b0;
        else if (st_q == JBF_TX_RSP_WAIT && link_ev.eod && rsp_armed_q)
            rx_rsp_q <= 1'b1;
        else if ((rx_rsp_q && link_ev.eod) || link_ev.idle)
            rx_rsp_q <= 1'b0;
    end

    // complete-frame flag held until the host pops a completion code
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rx_frame_done <= 1'b0;
        else if (link_ev.eod || link_ev.brk)
            rx_frame_done <= 1'b1;
        else if (rx_pop && rx_head.is_cc)
            rx_frame_done <= 1'b0;
    end

    jbf_rx_fifo u_rx_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push(rx_push),
        .push_data(rx_push_data),
        .pop(rx_pop),
        .head(rx_head),
        .empty(rx_empty),
        .full(rx_full),
        .level(rx_level)
    );

    // level-driven interrupt, registered: follows fifo and frame state one cycle later
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_n <= 1'b1;
        else
            irq_n <= !(irq_enable && ((rx_level > RX_IRQ_LEVEL)
                || rx_frame_done
                || (block_q && !have_last_q && tcnt_q <= TX_HALF)));
    end

endmodule : jbf_frame_ctrl

`default_nettype wire

// ==== src/jbf_pkg.sv ====
// shared constants and types of the frame-control block
package jbf_pkg;

    // ------------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------------
    localparam int GEN_HI = 7;
    localparam int GEN_LO = 5;
    localparam int BTD_HI = 4;
    localparam int BTD_LO = 2;

    // general action codes
    localparam logic [2:0] GA_NONE = 3'h0;
    localparam logic [2:0] GA_STANDBY = 3'h1;
    localparam logic [2:0] GA_BREAK = 3'h2;
    localparam logic [2:0] GA_RSP_CRC = 3'h3;
    localparam logic [2:0] GA_END_RETRY = 3'h4;
    localparam logic [2:0] GA_RSP_NOCRC = 3'h5;
    localparam logic [2:0] GA_RESERVED = 3'h6;
    localparam logic [2:0] GA_ABORT = 3'h7;

    // byte type and destination codes
    localparam logic [2:0] BT_NONE = 3'h0;
    localparam logic [2:0] BT_DATA = 3'h1;
    localparam logic [2:0] BT_LAST = 3'h3;
    localparam logic [2:0] BT_CFG = 3'h4;
    localparam logic [2:0] BT_FIRST = 3'h5;
    localparam logic [2:0] BT_CFG_NOW = 3'h6;
    localparam logic [2:0] BT_FIRST_LAST = 3'h7;

    // ------------------------------------------------------------------
    // fifo sizing and thresholds
    // ------------------------------------------------------------------
    localparam int TX_DEPTH = 4;
    localparam int TX_AW = 2;
    localparam int RX_DEPTH = 32;
    localparam int RX_AW = 5;
    localparam logic [RX_AW:0] RX_IRQ_LEVEL = 6'h0C;
    localparam logic [TX_AW:0] TX_HALF = 3'h2;

    // tx status field encoding
    localparam logic [1:0] TXS_EMPTY = 2'h0;
    localparam logic [1:0] TXS_SOME = 2'h1;
    localparam logic [1:0] TXS_ALMOST = 2'h2;
    localparam logic [1:0] TXS_FULL = 2'h3;

    // ------------------------------------------------------------------
    // completion code bits
    // ------------------------------------------------------------------
    localparam int CC_RSP = 7;
    localparam int CC_RSP_CRC = 6;
    localparam int CC_BREAK = 5;
    localparam int CC_OVERRUN = 4;
    localparam int CC_UNDERRUN = 3;
    localparam int CC_ARB_LOST = 2;
    localparam int CC_CRC_ERR = 1;
    localparam int CC_ERR = 0;

    // one entry of the receive fifo: data or completion code
    typedef struct packed {
        logic is_cc;
        logic [7:0] value;
    } jbf_rx_entry_t;

    // one entry of the transmit fifo
    typedef struct packed {
        logic last;
        logic [7:0] value;
    } jbf_tx_entry_t;

    // events reported by the symbol layer
    typedef struct packed {
        logic sof;
        logic eod;
        logic eof;
        logic idle;
        logic brk;
        logic rx_byte;
        logic [7:0] rx_data;
        logic crc_ok;
        logic rx_err;
        logic arb_lost;
        logic tx_err;
        logic tx_done_byte;
    } jbf_link_ev_t;

    typedef enum logic [2:0] {
        JBF_TX_IDLE,
        JBF_TX_WAIT_BUS,
        JBF_TX_SEND,
        JBF_TX_CRC,
        JBF_TX_RSP_WAIT
    } jbf_tx_state_t;

endpackage : jbf_pkg

// ==== src/jbf_rx_fifo.sv ====
// receive fifo holding frame bytes and completion codes
`timescale 1ns/1ps
`default_nettype none

module jbf_rx_fifo
    import jbf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic push,
    input wire jbf_rx_entry_t push_data,
    input wire logic pop,
    output jbf_rx_entry_t head,
    output logic empty,
    output logic full,
    output logic [RX_AW:0] level
);

    jbf_rx_entry_t mem [RX_DEPTH];
    logic [RX_AW-1:0] wr_q;
    logic [RX_AW-1:0] rd_q;
    logic [RX_AW:0] cnt_q;
    logic do_push;
    logic do_pop;

    // a push into a full fifo is refused; caller sees full
    assign do_push = push && (cnt_q != RX_AW'(0) + (RX_AW+1)'(RX_DEPTH));
    assign do_pop = pop && (cnt_q != '0);
    assign empty = (cnt_q == '0);
    assign full = (cnt_q == (RX_AW+1)'(RX_DEPTH));
    assign level = cnt_q;

    // storage without reset, only pointers are controlled
    always_ff @(posedge clk_sys)
    begin
        if (do_push)
            mem[wr_q] <= push_data;
    end

    // head register so the data output comes from a flop
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            head <= '0;
        else
            head <= mem[rd_q];
    end

    // pointers and occupancy
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (do_push)
                wr_q <= wr_q + RX_AW'(1);
            if (do_pop)
                rd_q <= rd_q + RX_AW'(1);
            cnt_q <= cnt_q + (RX_AW+1)'(do_push) - (RX_AW+1)'(do_pop);
        end
    end

endmodule : jbf_rx_fifo

`default_nettype wire
